/* File: design/flash_core_host.sv */
`timescale 1ns/100ps
`include "flash_self_access_map.svh"
module flash_core_host
   import flash_self_access_pkg::*;
(
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic [`APB_ADDR_W-1:0] paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Device side
   flash_core_if.core                  dev
);

   host_state_t st_reg;
   host_state_t st_next;
   logic        wr_take;
   logic        mapped;
   logic [31:0] rd_mux;
   host_cmd_t   cmd;

   // Stall holds the bus off, so no request reaches a device mid long write
   // Read data is a flop, so a wait state ends only after one capture in a ready cycle
   assign pready  = (st_reg.phase == HS_IDLE) & ~dev.stall & st_reg.rd_fresh;
   assign mapped  = (paddr == `OFS_PTR) | (paddr == `OFS_DATA) | (paddr == `OFS_CTRL) |
                    (paddr == `OFS_CMD) | (paddr == `OFS_STATUS);
   assign pslverr = psel & penable & pready & ~mapped;
   assign wr_take = psel & penable & pready & pwrite & mapped;
   assign cmd     = host_cmd_t'(pwdata[`CMD_CODE_LSB +: 3]);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `OFS_PTR:    rd_mux = {10'h000, dev.table_pointer};
         `OFS_DATA:   rd_mux = {24'h00_0000, dev.table_latch};
         `OFS_CTRL:   rd_mux = {24'h00_0000, dev.memory_control_reg};
         `OFS_STATUS: rd_mux = {29'h0000_0000, dev.completion_irq_flag, dev.stall, st_reg.phase != HS_IDLE};
         default:     rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      st_next             = st_reg;
      st_next.rd_op       = 1'b0;
      st_next.wr_op       = 1'b0;
      st_next.ptr_load    = 1'b0;
      st_next.latch_load  = 1'b0;
      st_next.ctrl_load   = 1'b0;
      st_next.unlock_load = 1'b0;
      st_next.irq_clear   = 1'b0;
      st_next.dev_reset   = 1'b0;
      st_next.rd_fresh    = psel & (st_reg.phase == HS_IDLE) & ~dev.stall;
      if (psel) begin
         st_next.prdata = rd_mux;
      end
      case (st_reg.phase)
         HS_IDLE: begin
            if (wr_take) begin
               case (paddr)
                  `OFS_PTR: begin
                     st_next.ptr_load = 1'b1;
                     st_next.ptr_data = pwdata[`PTR_W-1:0];
                  end
                  `OFS_DATA: begin
                     st_next.latch_load = 1'b1;
                     st_next.latch_data = pwdata[7:0];
                  end
                  `OFS_CTRL: begin
                     // Set up select and enable bits before unlocking
                     st_next.ctrl_load   = 1'b1;
                     st_next.ctrl_data   = pwdata[7:0];
                     st_next.ctrl_shadow = pwdata[7:0];
                  end
                  `OFS_STATUS: st_next.irq_clear = pwdata[`STAT_IRQ];
                  default: begin
                     st_next.mode = ptr_mode_t'(pwdata[`CMD_MODE_LSB +: 2]);
                     case (cmd)
                        CMD_READ:  st_next.rd_op = 1'b1;
                        CMD_WRITE: st_next.wr_op = 1'b1;
                        CMD_RESET: st_next.dev_reset = 1'b1;
                        CMD_START: begin
                           st_next.phase       = HS_KEY1;
                           st_next.unlock_load = 1'b1;
                           st_next.unlock_data = `UNLOCK_KEY1;
                        end
                        default: st_next.phase = HS_IDLE;
                     endcase
                  end
               endcase
            end
         end
         HS_KEY1: begin
            st_next.phase       = HS_KEY2;
            st_next.unlock_load = 1'b1;
            st_next.unlock_data = `UNLOCK_KEY2;
         end
         HS_KEY2: begin
            // Start follows the second key with no gap in between
            st_next.phase     = HS_GO;
            st_next.ctrl_load = 1'b1;
            st_next.ctrl_data = st_reg.ctrl_shadow | (8'h01 << `CTRL_START);
         end
         HS_GO:   st_next.phase = HS_HOLD;
         HS_HOLD: begin
            if (!dev.stall) begin
               st_next.phase = HS_IDLE;
            end
         end
         default: st_next.phase = HS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata          = st_reg.prdata;
   assign dev.rd_op       = st_reg.rd_op;
   assign dev.wr_op       = st_reg.wr_op;
   assign dev.ptr_mode    = st_reg.mode;
   assign dev.ptr_load    = st_reg.ptr_load;
   assign dev.ptr_data    = st_reg.ptr_data;
   assign dev.latch_load  = st_reg.latch_load;
   assign dev.latch_data  = st_reg.latch_data;
   assign dev.ctrl_load   = st_reg.ctrl_load;
   assign dev.ctrl_data   = st_reg.ctrl_data;
   assign dev.unlock_load = st_reg.unlock_load;
   assign dev.unlock_data = st_reg.unlock_data;
   assign dev.irq_clear   = st_reg.irq_clear;
   assign dev.dev_reset   = st_reg.dev_reset;

endmodule

/* File: design/flash_core_if.sv */
`timescale 1ns/100ps
interface flash_core_if;
   import flash_self_access_pkg::*;

   // Core requests
   logic        rd_op;
   logic        wr_op;
   ptr_mode_t   ptr_mode;
   logic        ptr_load;
   logic [21:0] ptr_data;
   logic        latch_load;
   logic [7:0]  latch_data;
   logic        ctrl_load;
   logic [7:0]  ctrl_data;
   logic        unlock_load;
   logic [7:0]  unlock_data;
   logic        irq_clear;
   logic        dev_reset;
   // Device state seen by the core
   logic [21:0] table_pointer;
   logic [7:0]  table_latch;
   logic [7:0]  memory_control_reg;
   logic        stall;
   logic        completion_irq_flag;

   modport dev (
      input  rd_op, wr_op, ptr_mode, ptr_load, ptr_data, latch_load, latch_data,
      input  ctrl_load, ctrl_data, unlock_load, unlock_data, irq_clear, dev_reset,
      output table_pointer, table_latch, memory_control_reg, stall, completion_irq_flag
   );

   modport core (
      output rd_op, wr_op, ptr_mode, ptr_load, ptr_data, latch_load, latch_data,
      output ctrl_load, ctrl_data, unlock_load, unlock_data, irq_clear, dev_reset,
      input  table_pointer, table_latch, memory_control_reg, stall, completion_irq_flag
   );
endinterface

/* File: design/flash_self_access.sv */
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "flash_self_access_map.svh"
module flash_self_access
   import flash_self_access_pkg::*;
#(
   parameter int unsigned prog_cycles = `PROG_TIME_US * `PCLK_MHZ
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Core side
   flash_core_if.dev core,
   // Array side
   output logic      pump_on,
   output logic      erase_active
);

   localparam int FLASH_AW    = `FLASH_ROW_BITS + `ROW_LSB;
   localparam int FLASH_WORDS = 1 << (FLASH_AW - 1);

   dev_state_t  st_reg;
   dev_state_t  st_next;
   logic [15:0] flash_mem [FLASH_WORDS];
   logic [15:0] row_word [`ROW_WORDS];
   logic [21:0] acc_addr;
   logic [15:0] rd_word;
   logic [`FLASH_ROW_BITS-1:0] row_sel;
   logic        commit;
   logic        commit_erase;
   logic        to_array;
   logic        start_req;
   logic        irq_set;
   logic [7:0]  ctrl_view;

   // Pointer steps touch only the low 21 bits; the top bit keeps its space choice
   function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic up);
      logic [20:0] low;
      low = up ? p[`PTR_LOW_W-1:0] + 21'h00_0001 : p[`PTR_LOW_W-1:0] - 21'h00_0001;
      return {p[`PTR_W-1], low};
   endfunction

   // Pre-increment accesses the stepped address
   assign acc_addr = (core.ptr_mode == PTR_PRE_INC) ? ptr_step(st_reg.ptr, 1'b1) : st_reg.ptr;
   assign rd_word  = flash_mem[acc_addr[FLASH_AW-1:1]];
   // Only the small modelled array is decoded; upper row bits alias
   assign row_sel  = st_reg.ptr[`ROW_LSB +: `FLASH_ROW_BITS];
   assign to_array = st_reg.pgm_sel & ~st_reg.cfg_sel;
   assign start_req = core.ctrl_load & core.ctrl_data[`CTRL_START] & ~st_reg.start;

   // Next row contents, one word per lane
   genvar w;
   generate
      for (w = 0; w < `ROW_WORDS; w++) begin : g_row
         logic [15:0] cur;
         assign cur = flash_mem[{row_sel, 5'(w)}];
         // Erase wipes the full row; programming can only clear bits
         assign row_word[w] = commit_erase ? `ERASED_WORD
                            : cur & {st_reg.hold[2*w+1], st_reg.hold[2*w]};
      end
   endgenerate

   always_comb begin
      st_next      = st_reg;
      commit       = 1'b0;
      commit_erase = st_reg.erase_sel;
      irq_set      = 1'b0;
      // Unlock keys must land in back-to-back cycles with start right after
      if (core.unlock_load && core.unlock_data == `UNLOCK_KEY1) begin
         st_next.unlock_stage = 2'h1;
      end else if (st_reg.unlock_stage == 2'h1 && core.unlock_load && core.unlock_data == `UNLOCK_KEY2) begin
         st_next.unlock_stage = 2'h2;
      end else begin
         st_next.unlock_stage = 2'h0;
      end
      if (core.dev_reset) begin
         // Memory select bits survive so the error can be traced
         if (st_reg.phase == PH_LONG) begin
            st_next.write_error_flag = 1'b1;
         end
         st_next.phase        = PH_IDLE;
         st_next.timer        = '0;
         st_next.start        = 1'b0;
         st_next.write_enable_bit         = 1'b0;
         st_next.erase_sel    = 1'b0;
         st_next.ptr          = '0;
         st_next.latch        = '0;
         st_next.unlock_stage = 2'h0;
         st_next.hold         = {`HOLD_BYTES{`HOLD_RESET}};
      end else if (st_reg.phase == PH_LONG) begin
         // Pointer, latch, read, write and control requests are not served while it is stalled
         if (st_reg.timer == '0) begin
            commit            = to_array;
            st_next.phase     = PH_IDLE;
            st_next.start     = 1'b0;
            st_next.erase_sel = 1'b0;
            st_next.write_error_flag     = 1'b0;
            st_next.hold      = {`HOLD_BYTES{`HOLD_RESET}};
            irq_set           = 1'b1;
         end else begin
            st_next.timer = st_reg.timer - 17'h0_0001;
         end
      end else begin
         if (core.ptr_load) begin
            st_next.ptr = core.ptr_data;
         end
         if (core.latch_load) begin
            st_next.latch = core.latch_data;
         end
         if (core.rd_op || core.wr_op) begin
            if (core.rd_op) begin
               st_next.latch = acc_addr[0] ? rd_word[15:8] : rd_word[7:0];
            end else begin
               // Short write: only the holding byte changes
               st_next.hold[acc_addr[`ROW_LSB-1:0]] = st_reg.latch;
            end
            case (core.ptr_mode)
               PTR_KEEP:     st_next.ptr = st_reg.ptr;
               PTR_POST_INC: st_next.ptr = ptr_step(st_reg.ptr, 1'b1);
               PTR_POST_DEC: st_next.ptr = ptr_step(st_reg.ptr, 1'b0);
               PTR_PRE_INC:  st_next.ptr = acc_addr;
               default:      st_next.ptr = st_reg.ptr;
            endcase
         end
         if (core.ctrl_load) begin
            st_next.pgm_sel   = core.ctrl_data[`CTRL_PGM_SEL];
            st_next.cfg_sel   = core.ctrl_data[`CTRL_CFG_SEL];
            st_next.erase_sel = core.ctrl_data[`CTRL_ERASE_SEL];
            st_next.write_enable_bit      = core.ctrl_data[`CTRL_WRITE_ENABLE_BIT];
            st_next.write_error_flag     = core.ctrl_data[`CTRL_WRITE_ERROR_FLAG];
            if (start_req) begin
               // Enable must already be set before the unlocked start
               if (st_reg.write_enable_bit && st_reg.unlock_stage == 2'h2) begin
                  st_next.start = 1'b1;
                  st_next.phase = PH_LONG;
                  // Counting down to zero gives exactly prog_cycles stall cycles
                  st_next.timer = 17'(prog_cycles - 1);
                  st_next.write_error_flag = 1'b1;
               end else begin
                  st_next.write_error_flag = 1'b1;
               end
            end
         end
      end
      // A completion in the clearing cycle keeps the flag set
      st_next.irq = irq_set | (st_reg.irq & ~core.irq_clear);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg              <= '0;
         st_reg.hold         <= {`HOLD_BYTES{`HOLD_RESET}};
      end else begin
         st_reg <= st_next;
      end
   end

   // Array is nonvolatile, so it has no reset; a whole row is written at once
   always_ff @(posedge pclk) begin
      if (commit) begin
         for (int i = 0; i < `ROW_WORDS; i++) begin
            flash_mem[{row_sel, i[4:0]}] <= row_word[i];
         end
      end
   end

   // Unused bits 5 and 0 read as zero
   always_comb begin
      ctrl_view                  = 8'h00;
      ctrl_view[`CTRL_PGM_SEL]   = st_reg.pgm_sel;
      ctrl_view[`CTRL_CFG_SEL]   = st_reg.cfg_sel;
      ctrl_view[`CTRL_ERASE_SEL] = st_reg.erase_sel;
      ctrl_view[`CTRL_WRITE_ERROR_FLAG]     = st_reg.write_error_flag;
      ctrl_view[`CTRL_WRITE_ENABLE_BIT]      = st_reg.write_enable_bit;
      ctrl_view[`CTRL_START]     = st_reg.start;
   end

   assign core.table_pointer       = st_reg.ptr;
   assign core.table_latch         = st_reg.latch;
   assign core.memory_control_reg  = ctrl_view;
   assign core.stall               = (st_reg.phase == PH_LONG);
   assign core.completion_irq_flag = st_reg.irq;
   assign pump_on                  = (st_reg.phase == PH_LONG);
   assign erase_active             = (st_reg.phase == PH_LONG) & st_reg.erase_sel;

endmodule

/* File: design/flash_self_access_map.svh */
`ifndef FLASH_SELF_ACCESS_MAP_SVH
`define FLASH_SELF_ACCESS_MAP_SVH

// Pointer and row geometry
`define PTR_W          22
`define PTR_LOW_W      21
`define ROW_LSB        6
`define ROW_WORDS      32
`define HOLD_BYTES     64
`define FLASH_ROW_BITS 2

// Control register bit positions
`define CTRL_PGM_SEL   7
`define CTRL_CFG_SEL   6
`define CTRL_ERASE_SEL 4
`define CTRL_WRITE_ERROR_FLAG     3
`define CTRL_WRITE_ENABLE_BIT      2
`define CTRL_START     1

// Unlock keys and reset values
`define UNLOCK_KEY1    8'h55
`define UNLOCK_KEY2    8'hAA
`define HOLD_RESET     8'hFF
`define ERASED_WORD    16'hFFFF

// Long write timing
`define PROG_TIME_US   2000
`define PCLK_MHZ       40
`define TIMER_W        17

// Host register offsets and fields
`define APB_ADDR_W     8
`define OFS_PTR        8'h00
`define OFS_DATA       8'h04
`define OFS_CTRL       8'h08
`define OFS_CMD        8'h0C
`define OFS_STATUS     8'h10
`define CMD_CODE_LSB   0
`define CMD_MODE_LSB   4
`define STAT_BUSY      0
`define STAT_STALL     1
`define STAT_IRQ       2

`endif

/* File: design/flash_self_access_pkg.sv */
package flash_self_access_pkg;

   typedef enum logic [1:0] {
      PTR_KEEP     = 2'h0,
      PTR_POST_INC = 2'h1,
      PTR_POST_DEC = 2'h2,
      PTR_PRE_INC  = 2'h3
   } ptr_mode_t;

   typedef enum logic [2:0] {
      CMD_NONE   = 3'h0,
      CMD_READ   = 3'h1,
      CMD_WRITE  = 3'h2,
      CMD_START  = 3'h3,
      CMD_RESET  = 3'h4
   } host_cmd_t;

   typedef enum logic {
      PH_IDLE = 1'b0,
      PH_LONG = 1'b1
   } dev_phase_t;

   typedef enum logic [2:0] {
      HS_IDLE   = 3'h0,
      HS_KEY1   = 3'h1,
      HS_KEY2   = 3'h2,
      HS_GO     = 3'h3,
      HS_HOLD   = 3'h4
   } host_phase_t;

   typedef struct packed {
      dev_phase_t       phase;
      logic [16:0]      timer;
      logic [21:0]      ptr;
      logic [7:0]       latch;
      logic             pgm_sel;
      logic             cfg_sel;
      logic             erase_sel;
      logic             write_error_flag;
      logic             write_enable_bit;
      logic             start;
      logic [1:0]       unlock_stage;
      logic             irq;
      logic [63:0][7:0] hold;
   } dev_state_t;

   typedef struct packed {
      host_phase_t phase;
      logic        rd_op;
      logic        wr_op;
      ptr_mode_t   mode;
      logic        ptr_load;
      logic [21:0] ptr_data;
      logic        latch_load;
      logic [7:0]  latch_data;
      logic        ctrl_load;
      logic [7:0]  ctrl_data;
      logic [7:0]  ctrl_shadow;
      logic        unlock_load;
      logic [7:0]  unlock_data;
      logic        irq_clear;
      logic        dev_reset;
      logic        rd_fresh;
      logic [31:0] prdata;
   } host_state_t;

endpackage

/* File: testbench/flash_self_access_assertions.sv */
`timescale 1ns/100ps
module flash_self_access_assertions
   import flash_self_access_pkg::*;
#(
   parameter int unsigned prog_cycles = 20
) (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Core requests
   input wire logic        rd_op,
   input wire ptr_mode_t   ptr_mode,
   input wire logic        ptr_load,
   input wire logic        ctrl_load,
   input wire logic [7:0]  ctrl_data,
   input wire logic        unlock_load,
   input wire logic [7:0]  unlock_data,
   input wire logic        irq_clear,
   input wire logic        dev_reset,
   // Device state
   input wire logic [21:0] table_pointer,
   input wire logic [7:0]  memory_control_reg,
   input wire logic        stall,
   input wire logic        completion_irq_flag
);
   logic [31:0] stall_cnt_reg;

   // Counts stall cycles so the long write length can be checked exactly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_cnt_reg <= '0;
      end else if (stall) begin
         stall_cnt_reg <= stall_cnt_reg + 32'd1;
      end else begin
         stall_cnt_reg <= '0;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_start_runs;
      ctrl_load && ctrl_data[1] && memory_control_reg[2] && !memory_control_reg[1] && !stall && !dev_reset
         && $past(unlock_load) && $past(unlock_data) == 8'hAA && $past(unlock_load, 2)
         && $past(unlock_data, 2) == 8'h55 && !$past(stall) && !$past(stall, 2) |=> stall;
   endproperty
   a_start_runs: assert property (p_start_runs) else $error("unlocked start did not stall");

   property p_improper;
      ctrl_load && ctrl_data[1] && !stall && !memory_control_reg[1] && !dev_reset
         && !($past(unlock_load) && $past(unlock_data) == 8'hAA) |=> !stall && memory_control_reg[3];
   endproperty
   a_improper: assert property (p_improper) else $error("start without unlock not refused");

   property p_stall_len;
      $fell(stall) && !$past(dev_reset) |-> stall_cnt_reg == prog_cycles;
   endproperty
   a_stall_len: assert property (p_stall_len) else $error("long write length wrong");

   property p_done;
      $fell(stall) && !$past(dev_reset) |-> completion_irq_flag && memory_control_reg[4:3] == 2'b00
         && !memory_control_reg[1];
   endproperty
   a_done: assert property (p_done) else $error("completion flags wrong");

   property p_irq_sticky;
      completion_irq_flag && !irq_clear && !dev_reset |=> completion_irq_flag;
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("irq flag dropped alone");

   property p_start_held;
      stall |-> memory_control_reg[1];
   endproperty
   a_start_held: assert property (p_start_held) else $error("start bit low during long write");

   property p_ptr_inc;
      rd_op && ptr_mode == PTR_POST_INC && !stall && !ptr_load && !dev_reset
         |=> table_pointer[20:0] == $past(table_pointer[20:0]) + 21'd1;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not incremented");

   property p_stall_cause;
      $rose(stall) |-> $past(ctrl_load) && $past(ctrl_data[1]);
   endproperty
   a_stall_cause: assert property (p_stall_cause) else $error("stall without start write");
endmodule

/* File: testbench/tb_program_flash_self_access.sv */
`timescale 1ns/100ps
module tb_program_flash_self_access;
   import flash_self_access_pkg::*;
   localparam int unsigned prog_len = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
   logic        pump_on, erase_active, erase_mode;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, lfsr;
   logic [21:0] ptr;
   logic [7:0]  mem [256];
   logic [7:0]  hold [64];
   int          err_count, checked, cycles;

   flash_core_if cif ();
   flash_self_access #(.prog_cycles(prog_len)) flash_self_access_inst (.pclk(pclk), .presetn(presetn),
      .core(cif), .pump_on(pump_on), .erase_active(erase_active));
   flash_core_host flash_core_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dev(cif));
   flash_self_access_assertions #(.prog_cycles(prog_len)) flash_self_access_assertions_inst (
      .pclk(pclk), .presetn(presetn), .rd_op(cif.rd_op), .ptr_mode(cif.ptr_mode), .ptr_load(cif.ptr_load),
      .ctrl_load(cif.ctrl_load), .ctrl_data(cif.ctrl_data), .unlock_load(cif.unlock_load),
      .unlock_data(cif.unlock_data), .irq_clear(cif.irq_clear), .dev_reset(cif.dev_reset),
      .table_pointer(cif.table_pointer), .memory_control_reg(cif.memory_control_reg),
      .stall(cif.stall), .completion_irq_flag(cif.completion_irq_flag));

   always #12.5 pclk = ~pclk;

   task conclude;
      if (err_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Holds the request until pready, no fixed slave latency assumed
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   function logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task setp(input logic [21:0] p);
      apb(8'h00, 1'b1, {10'h0, p});
      ptr = p;
   endtask

   task tread(input int m);
      logic [7:0] e;
      if (m == 3) ptr[20:0] = ptr[20:0] + 21'd1;
      e = mem[ptr[7:0]];
      apb(8'h0C, 1'b1, 32'h1 | (m << 4));
      if (m == 1) ptr[20:0] = ptr[20:0] + 21'd1;
      if (m == 2) ptr[20:0] = ptr[20:0] - 21'd1;
      repeat (2) @(posedge pclk);
      apb(8'h04, 1'b0, 32'h0);
      chk(rd, {24'h0, e});
      apb(8'h00, 1'b0, 32'h0);
      chk(rd, {10'h0, ptr});
   endtask

   task twrite(input logic [7:0] v);
      apb(8'h04, 1'b1, {24'h0, v});
      apb(8'h0C, 1'b1, 32'h12);
      hold[ptr[5:0]] = v;
      ptr[20:0] = ptr[20:0] + 21'd1;
   endtask

   task start(input logic [7:0] c, input logic e);
      apb(8'h08, 1'b1, {24'h0, c});
      erase_mode = e;
      apb(8'h0C, 1'b1, 32'h3);
      for (int i = 0; i < 64; i++) begin
         // Array only changes with program memory selected and config space off
         if (c[7] && !c[6]) mem[{ptr[7:6], i[5:0]}] = e ? 8'hFF : (mem[{ptr[7:6], i[5:0]}] & hold[i]);
         hold[i] = 8'hFF;
      end
      apb(8'h10, 1'b0, 32'h0);
      chk(rd, 32'h4);
      apb(8'h08, 1'b0, 32'h0);
      chk(rd, {24'h0, c & 8'hE5});
      apb(8'h10, 1'b1, 32'h4);
      apb(8'h10, 1'b0, 32'h0);
      chk(rd, 32'h0);
   endtask

   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      err_count = 0; checked = 0; cycles = 0; lfsr = 32'hd6e8; erase_mode = 0;
      for (int i = 0; i < 64; i++) hold[i] = 8'hFF;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(8'h08, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(8'h14, 1'b0, 32'h0);
      chk({rd[30:0], err_seen}, 32'h1);
      // Low pointer bits set on purpose: erase must ignore them
      for (int r = 0; r < 4; r++) begin
         setp({14'h0, r[1:0], 6'h2B});
         start(8'h94, 1'b1);
      end
      // Two passes over one row: second pass can only clear bits
      for (int p = 0; p < 2; p++) begin
         setp(22'h045);
         for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            twrite(lfsr[7:0]);
         end
         start(8'h84, 1'b0);
      end
      setp(22'h040);
      repeat (64) tread(1);
      setp(22'h07F);
      for (int m = 0; m < 4; m++) tread(m);
      // Config space selected: timer runs, array byte must stay as it was
      setp(22'h040);
      twrite(8'h00);
      start(8'hC4, 1'b0);
      setp(22'h040);
      tread(0);
      apb(8'h08, 1'b1, 32'h86);
      apb(8'h08, 1'b0, 32'h0);
      chk(rd, 32'h8C);
      apb(8'h10, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(8'h0C, 1'b1, 32'h4);
      repeat (2) @(posedge pclk);
      apb(8'h08, 1'b0, 32'h0);
      chk(rd & 32'hF7, 32'h80);
      conclude;
   end

   always @(posedge pclk) begin
      cycles++;
      if (cif.stall === 1'b1) begin
         chk({31'h0, pump_on}, 32'h1);
         chk({31'h0, erase_active}, {31'h0, erase_mode});
      end
      if (cycles > 20000) begin
         err_count++;
         conclude;
      end
   end
endmodule
